/* design/lsac_pkg.sv */
// lsac_pkg: constants, types and register layout of the emitter and ambient configuration block
package lsac_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_LED_CUR = 8'h83;
	localparam logic [7:0] ADDR_AMB_PAR = 8'h84;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// emitter current register fields
	localparam int CUR_LSB = 0;
	localparam int CUR_W = 6;
	localparam int REV_LSB = 6;
	localparam int REV_W = 2;
	localparam logic [5:0] CUR_RST = 6'h02;
	localparam logic [5:0] CUR_MAX = 6'h14;
	localparam logic [7:0] LED_STEP_MA = 8'h0A;
	localparam logic [7:0] LED_MAX_MA = 8'hC8;
	// ambient parameter register fields
	localparam int CONT_BIT = 7;
	localparam int RATE_LSB = 4;
	localparam int RATE_W = 3;
	localparam int AOC_BIT = 3;
	localparam int AVG_LSB = 0;
	localparam int AVG_W = 3;
	localparam logic [7:0] AMB_RST = 8'h0D;
	// ==========================================================
	// timing
	localparam int CLK_NS = 40;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ONE_SEC_NS = 1000000000;
	localparam int ONE_SEC_CYC = ONE_SEC_NS / CLK_NS;
	localparam int DATA_W = 16;
	// ==========================================================
	// types
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lsac_reg_req_s;
	typedef struct packed {
		logic done;
		logic [15:0] data;
	} lsac_conv_res_s;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_GAP = 2'b01,
		ST_CONV = 2'b10,
		ST_DONE = 2'b11
	} lsac_state_e;
endpackage

/* design/lsac_avg.sv */
// lsac_avg: accumulator that averages a power-of-two number of conversions
`timescale 1ns/1ps
module lsac_avg #(
	parameter int DATA_W = 16,
	parameter int LOG_W = 3
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// accumulate control
	input wire logic clr_i,
	input wire logic add_i,
	input wire logic [DATA_W-1:0] data_i,
	input wire logic [LOG_W-1:0] log2n_i,
	// average of what was summed
	output logic [DATA_W-1:0] avg_o
);
	localparam int ACC_W = DATA_W + (1 << LOG_W) - 1;
	logic [ACC_W-1:0] acc_q, acc_d;
	initial begin
		if (DATA_W < 1 || LOG_W < 1 || LOG_W > 4) $error("lsac_avg: bad parameters");
	end
	// sum next value
	always_comb begin
		acc_d = acc_q;
		if (clr_i) begin
			acc_d = '0;
		end else if (add_i) begin
			acc_d = acc_q + ACC_W'(data_i);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_d;
		end
	end
	// divide by the count through a shift
	assign avg_o = DATA_W'(acc_q >> log2n_i);
endmodule // lsac_avg

/* design/lsac_top.sv */
// lsac_top: emitter current and ambient light parameter registers with conversion sequencer
// ==========================================================
// Overview of operation
// - The programmed emitter current is driven to the emitter only during proximity measurement.
// - Emitter drive equals the current field value times 10 mA for codes up to 20.
// - Codes above 20 drive the emitter at the 200 mA maximum.
// - After reset the current field holds code 2, that is 20 mA.
// - The upper current register bits return a fixed calibration revision that writes cannot change.
// - The continuous conversion bit enables fast conversions when one and resets to zero.
// - Continuous conversion with on-demand measurement skips the settle gap, so runs faster.
// - The offset compensation bit enables compensation when one and resets to one.
// - With compensation on, an offset is measured once per cycle, before its first ambient conversion, and subtracted.
// - The averaging field sets two to its value conversions per cycle, 1 to 128.
// - The ambient result is the average of all non-offset conversions of its cycle.
// - After reset the averaging field holds 101, that is 32 conversions.
// - During self-timed mode a new rate takes effect only after the mode is cycled.
`timescale 1ns/1ps
module lsac_top
	import lsac_pkg::*;
#(
	parameter int TICK_SEC_CYC = ONE_SEC_CYC,
	parameter logic [REV_W-1:0] CAL_REV = 2'h1 // value is arbitrary
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// register access from the management bus
	input wire lsac_reg_req_s req_i,
	output logic [7:0] rd_data_o,
	// measurement mode from the command logic
	input wire logic selftimed_en_i,
	input wire logic amb_en_i,
	input wire logic ambient_on_demand_trigger_i,
	input wire logic prox_active_i,
	// emitter drive
	output logic led_en_o,
	output logic [7:0] led_ma_o,
	// ambient converter
	input wire lsac_conv_res_s conv_i,
	output logic conv_start_o,
	output logic conv_offset_o,
	// ambient result
	output logic [DATA_W-1:0] result_o,
	output logic result_valid_o,
	output logic busy_o
);
	initial begin
		if (TICK_SEC_CYC < 8) $error("lsac_top: TICK_SEC_CYC too small");
	end
	// ==========================================================
	// registers
	logic [CUR_W-1:0] cur_q, cur_d;
	logic [7:0] amb_q, amb_d, rd_d;
	always_comb begin
		cur_d = cur_q;
		amb_d = amb_q;
		rd_d = RD_UNMAPPED;
		if (req_i.wr && req_i.addr == ADDR_LED_CUR) begin
			cur_d = req_i.wdata[CUR_LSB +: CUR_W]; // upper bits dropped
		end
		if (req_i.wr && req_i.addr == ADDR_AMB_PAR) begin
			amb_d = req_i.wdata;
		end
		if (req_i.rd && req_i.addr == ADDR_LED_CUR) begin
			rd_d = {CAL_REV, cur_q};
		end else if (req_i.rd && req_i.addr == ADDR_AMB_PAR) begin
			rd_d = amb_q;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cur_q <= CUR_RST;
			amb_q <= AMB_RST;
			rd_data_o <= RD_UNMAPPED;
		end else begin
			cur_q <= cur_d;
			amb_q <= amb_d;
			rd_data_o <= rd_d;
		end
	end
	wire logic cont_en = amb_q[CONT_BIT];
	wire logic aoc_en = amb_q[AOC_BIT];
	wire logic [AVG_W-1:0] avg_fld = amb_q[AVG_LSB +: AVG_W];
	wire logic [RATE_W-1:0] rate_fld = amb_q[RATE_LSB +: RATE_W];
	// ==========================================================
	// emitter drive
	logic [7:0] led_d;
	always_comb begin
		led_d = 8'h00;
		if (prox_active_i) begin
			led_d = (cur_q > CUR_MAX) ? LED_MAX_MA : 8'(cur_q * LED_STEP_MA);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			led_ma_o <= 8'h00;
			led_en_o <= 1'b0;
		end else begin
			led_ma_o <= led_d;
			led_en_o <= prox_active_i;
		end
	end
	// ==========================================================
	// periodic rate: period is one second divided by code plus one
	logic [RATE_W-1:0] rate_run_q, rate_run_d;
	logic [31:0] tick_q, tick_d;
	logic st_q;
	logic tick;
	always_comb begin
		rate_run_d = rate_run_q;
		if (!selftimed_en_i || !st_q) begin
			rate_run_d = rate_fld; // held while self-timed runs
		end
		tick = 1'b0;
		tick_d = 32'h0000_0000;
		if (selftimed_en_i) begin
			if (tick_q == 32'h0000_0000) begin
				tick = st_q;
				tick_d = 32'(TICK_SEC_CYC / (int'(rate_run_q) + 1) - 1);
			end else begin
				tick_d = tick_q - 32'h0000_0001;
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rate_run_q <= '0;
			tick_q <= 32'h0000_0000;
			st_q <= 1'b0;
		end else begin
			rate_run_q <= rate_run_d;
			tick_q <= tick_d;
			st_q <= selftimed_en_i;
		end
	end
	// ==========================================================
	// conversion sequencer
	localparam logic [4:0] GAP_LOAD = 5'(SETTLE_CYC - 1);
	lsac_state_e st_cur_q, st_nxt;
	logic ofs_ph_q, ofs_ph_d, start_d, clr, add, valid_d, busy_d, fast_q, fast_d;
	logic aoc_run_q, aoc_run_d;
	logic [AVG_W-1:0] avg_run_q, avg_run_d;
	logic [7:0] n_q, n_d;
	logic [4:0] gap_q, gap_d;
	logic [DATA_W-1:0] ofs_q, ofs_d, res_d, avg_val;
	wire logic od_trig = ambient_on_demand_trigger_i && !selftimed_en_i;
	wire logic trig = od_trig || (selftimed_en_i && amb_en_i && tick);
	lsac_avg #(.DATA_W(DATA_W), .LOG_W(AVG_W)) u_avg (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.clr_i(clr),
		.add_i(add),
		.data_i(conv_i.data),
		.log2n_i(avg_run_q),
		.avg_o(avg_val)
	);
	always_comb begin
		st_nxt = st_cur_q;
		ofs_ph_d = ofs_ph_q;
		aoc_run_d = aoc_run_q;
		avg_run_d = avg_run_q;
		fast_d = fast_q;
		n_d = n_q;
		gap_d = gap_q;
		ofs_d = ofs_q;
		res_d = result_o;
		start_d = 1'b0;
		clr = 1'b0;
		add = 1'b0;
		valid_d = 1'b0;
		busy_d = 1'b1;
		unique case (st_cur_q)
			ST_IDLE: begin
				busy_d = trig;
				if (trig) begin
					clr = 1'b1;
					n_d = 8'h00;
					aoc_run_d = aoc_en;
					ofs_ph_d = aoc_en; // offset conversion first
					avg_run_d = avg_fld;
					fast_d = cont_en && od_trig;
					gap_d = GAP_LOAD;
					st_nxt = ST_GAP;
				end
			end
			ST_GAP: begin
				if (fast_q || gap_q == 5'h00) begin // settle elapsed, or skipped in fast mode
					start_d = 1'b1;
					st_nxt = ST_CONV;
				end else begin
					gap_d = gap_q - 5'h01;
				end
			end
			ST_CONV: begin
				if (conv_i.done) begin
					gap_d = GAP_LOAD;
					st_nxt = ST_GAP;
					if (ofs_ph_q) begin
						ofs_d = conv_i.data;
						ofs_ph_d = 1'b0;
					end else begin
						add = 1'b1;
						n_d = n_q + 8'h01;
						if (n_d == (8'h01 << avg_run_q)) begin
							st_nxt = ST_DONE;
						end
					end
				end
			end
			ST_DONE: begin
				res_d = avg_val;
				if (aoc_run_q) begin
					res_d = (avg_val > ofs_q) ? avg_val - ofs_q : '0;
				end
				valid_d = 1'b1;
				busy_d = 1'b0;
				st_nxt = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_cur_q <= ST_IDLE;
			ofs_ph_q <= 1'b0;
			aoc_run_q <= 1'b0;
			avg_run_q <= '0;
			fast_q <= 1'b0;
			n_q <= 8'h00;
			gap_q <= 5'h00;
			ofs_q <= '0;
			result_o <= '0;
			result_valid_o <= 1'b0;
			busy_o <= 1'b0;
			conv_start_o <= 1'b0;
			conv_offset_o <= 1'b0;
		end else begin
			st_cur_q <= st_nxt;
			ofs_ph_q <= ofs_ph_d;
			aoc_run_q <= aoc_run_d;
			avg_run_q <= avg_run_d;
			fast_q <= fast_d;
			n_q <= n_d;
			gap_q <= gap_d;
			ofs_q <= ofs_d;
			result_o <= res_d;
			result_valid_o <= valid_d;
			busy_o <= busy_d;
			conv_start_o <= start_d;
			conv_offset_o <= ofs_ph_d;
		end
	end
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	led_off_a: assert property (!prox_active_i |=> led_ma_o == 8'h00 && !led_en_o)
		else $error("emitter driven outside proximity");
	led_scale_a: assert property (prox_active_i && cur_q <= CUR_MAX
		|=> led_ma_o == 8'($past(cur_q) * LED_STEP_MA))
		else $error("emitter current not code times step");
	led_clamp_a: assert property (prox_active_i && cur_q > CUR_MAX |=> led_ma_o == LED_MAX_MA)
		else $error("emitter current not clamped");
	reset_vals_a: assert property ($past(sys_rst_i) |-> cur_q == CUR_RST && amb_q == AMB_RST)
		else $error("wrong reset values");
	rev_read_a: assert property (req_i.rd && req_i.addr == ADDR_LED_CUR
		|=> rd_data_o == {CAL_REV, $past(cur_q)})
		else $error("calibration revision read wrong");
	fast_gap_a: assert property (st_cur_q == ST_GAP && fast_q |=> conv_start_o)
		else $error("fast mode did not start at once");
	offset_first_a: assert property (st_cur_q == ST_IDLE && trig && aoc_en
		|=> conv_offset_o ##1 conv_offset_o)
		else $error("offset conversion not first");
	avg_count_a: assert property (st_cur_q == ST_DONE |-> n_q == (8'h01 << avg_run_q))
		else $error("wrong number of conversions");
	rate_hold_a: assert property (st_q && selftimed_en_i && $stable(selftimed_en_i)
		|=> $stable(rate_run_q))
		else $error("rate changed while self-timed");
	cov_ofs_c: cover property (st_cur_q == ST_DONE && aoc_run_q);
	cov_fast_c: cover property (st_cur_q == ST_GAP && fast_q);
	cov_clamp_c: cover property (prox_active_i && cur_q > CUR_MAX);
endmodule // lsac_top

/* tb/lsac_conv_model.sv */
// lsac_conv_model: behavioural ambient converter, one answer per start
`timescale 1ns/1ps
module lsac_conv_model
	import lsac_pkg::*;
#(
	parameter int LAT = 3,
	parameter logic [15:0] DARK = 16'h0010
) (
	// clock
	input wire logic clk_sys_i,
	// conversion control
	input wire logic start_i,
	input wire logic offset_i,
	// result
	output lsac_conv_res_s conv_o
);
	int cnt = 0;
	logic ph = 1'b0;
	initial conv_o = '{1'b0, 16'h5A5A};
	// data toggles when not valid so a stale value never looks right
	always @(negedge clk_sys_i) begin
		conv_o.done <= 1'b0;
		conv_o.data <= ~conv_o.data;
		if (start_i) begin
			cnt <= LAT;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				conv_o.done <= 1'b1;
				conv_o.data <= offset_i ? DARK : (ph ? 16'h0300 : 16'h0100);
				ph <= ph ^ ~offset_i;
			end
		end
	end
endmodule // lsac_conv_model

/* tb/tb_top.sv */
// tb_top: self-checking bench for the emitter and ambient configuration block
`timescale 1ns/1ps
module tb_top;
	import lsac_pkg::*;
	localparam int TICK = 64;
	localparam logic [1:0] REV = 2'h2; // value is arbitrary
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	lsac_reg_req_s req = '0;
	logic st_en = 1'b0;
	logic amb_en = 1'b0;
	logic trig = 1'b0;
	logic prox = 1'b0;
	lsac_conv_res_s conv;
	logic [7:0] rd_data, led_ma;
	logic led_en, c_start, c_off, r_valid, busy;
	logic [15:0] res;
	int fails = 0;
	int checks_done = 0;
	// ==========================================================
	// clock, design and converter
	always #20 clk_sys_i = ~clk_sys_i;
	lsac_top #(.TICK_SEC_CYC(TICK), .CAL_REV(REV)) i_dut (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .req_i(req), .rd_data_o(rd_data), .selftimed_en_i(st_en),
		.amb_en_i(amb_en), .ambient_on_demand_trigger_i(trig), .prox_active_i(prox),
		.led_en_o(led_en), .led_ma_o(led_ma), .conv_i(conv), .conv_start_o(c_start),
		.conv_offset_o(c_off), .result_o(res), .result_valid_o(r_valid), .busy_o(busy));
	lsac_conv_model i_conv (.clk_sys_i(clk_sys_i), .start_i(c_start), .offset_i(c_off),
		.conv_o(conv));
	// ==========================================================
	// compare and closing
	task chkv(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chkb(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// bounded wait on a design flag, cut short as a mismatch
	task automatic wait_hi(ref logic f, input int lim, output int n);
		n = 0;
		while (f !== 1'b1 && n < lim) begin
			@(negedge clk_sys_i);
			n++;
		end
		if (n >= lim) begin
			fails++;
			conclude;
		end
	endtask
	// ==========================================================
	// register access
	task reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		req <= '{1'b1, 1'b0, a, d};
		@(negedge clk_sys_i);
		req <= '0;
	endtask
	task reg_rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys_i);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk_sys_i);
		req <= '0;
		chkv("rd_data", {8'h00, e}, {8'h00, rd_data});
	endtask
	// ==========================================================
	// scenarios
	task t_reset;
		reg_rd(ADDR_LED_CUR, {REV, 6'h02});
		reg_rd(ADDR_AMB_PAR, {1'b0, 3'b000, 1'b1, 3'b101});
		reg_rd(8'h85, 8'h00);
	endtask
	task t_led;
		logic [5:0] code [5];
		logic [7:0] ma [5];
		code = '{6'h00, 6'h01, 6'h14, 6'h15, 6'h3F};
		ma = '{8'h00, 8'h0A, 8'hC8, 8'hC8, 8'hC8};
		for (int i = 0; i < 5; i++) begin
			reg_wr(ADDR_LED_CUR, {2'b11, code[i]});
			reg_rd(ADDR_LED_CUR, {REV, code[i]});
			@(negedge clk_sys_i);
			prox <= 1'b1;
			@(negedge clk_sys_i);
			chkv("led_ma", {8'h00, ma[i]}, {8'h00, led_ma});
			chkb("led_en", 1'b1, led_en);
			prox <= 1'b0;
			@(negedge clk_sys_i);
			chkv("led_ma idle", 16'h0000, {8'h00, led_ma});
		end
	endtask
	task t_meas(input logic [7:0] cfg, input int gap, input logic off, input logic [15:0] e);
		int n;
		reg_wr(ADDR_AMB_PAR, cfg);
		reg_rd(ADDR_AMB_PAR, cfg);
		@(negedge clk_sys_i);
		trig <= 1'b1;
		@(negedge clk_sys_i);
		trig <= 1'b0;
		chkb("busy", 1'b1, busy);
		wait_hi(c_start, 100, n);
		chkv("start delay", gap[15:0], 16'(n + 1));
		chkb("offset first", off, c_off);
		wait_hi(r_valid, 3000, n);
		chkv("result", e, res);
		chkb("busy end", 1'b0, busy);
	endtask
	task t_self(input logic [2:0] rate);
		int n;
		int p;
		p = TICK / (rate + 1);
		reg_wr(ADDR_AMB_PAR, {1'b0, rate, 4'b0000});
		@(negedge clk_sys_i);
		st_en <= 1'b1;
		amb_en <= 1'b1;
		// new rate while self-timed runs must stay parked
		reg_wr(ADDR_AMB_PAR, {1'b0, ~rate, 4'b0000});
		wait_hi(r_valid, 1000, n);
		chkb("rate period", 1'b1, n >= p && n <= p + 40);
		st_en <= 1'b0;
		amb_en <= 1'b0;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(negedge clk_sys_i);
		sys_rst_i <= 1'b0;
		t_reset;
		t_led;
		t_meas(8'h81, 2, 1'b0, 16'h0200);
		t_meas(8'h0A, 26, 1'b1, 16'h01F0);
		t_meas(8'h87, 2, 1'b0, 16'h0200);
		t_self(3'd0);
		t_self(3'd3);
		conclude;
	end
endmodule // tb_top
